//--- logic/sdc_config.sv
`timescale 1ns/10ps
module sdc_config (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic        mod_bit,
	output logic      [7:0]  rd_data,
	output logic             result_polarity_sel,
	output logic             burnout_source_en,
	output logic      [2:0]  gain_select,
	output logic      [7:0]  gain_factor,
	output logic      [2:0]  converter_system_mode,
	output logic             converter_en,
	output logic             modulator_clock,
	output logic             sample_en,
	output logic      [10:0] decimation_eff,
	output logic      [23:0] result,
	output logic             result_valid
);
	logic        [4:0]  control;
	logic        [2:0]  decimation_value_high;
	logic        [7:0]  decimation_value_low;
	logic        [7:0]  divisor;
	logic        [10:0] decimation_value;
	logic               idle;
	logic               wr_control;
	logic               wr_high;
	logic               wr_low;
	logic               wr_mode;
	logic               wr_divisor;
	logic               converting;
	logic        [10:0] sample_cnt;
	logic        [18:0] ones_acc;
	logic               word_end;
	logic        [18:0] bias;
	logic        [18:0] signed_word;
	logic        [4:0]  next_control;
	logic        [10:0] words_samples;

	sdc_clk_div u_clk_div (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.divisor    (divisor),
		.mod_clk_en (modulator_clock),
		.sample_en  (sample_en)
	);

	// Protected registers open only in idle, which is system mode zero.
	assign idle       = (converter_system_mode == sdc_pkg::SDC_SM_IDLE); // RQ6
	assign wr_control = wr_en && (addr == sdc_pkg::ADDR_CONTROL) && idle; // RQ5 RQ7
	assign wr_high    = wr_en && (addr == sdc_pkg::ADDR_DECIMATION_VALUE_HIGH) && idle; // RQ5 RQ7
	assign wr_low     = wr_en && (addr == sdc_pkg::ADDR_DECIMATION_VALUE_LOW) && idle; // RQ7
	assign wr_mode    = wr_en && (addr == sdc_pkg::ADDR_MODE);
	assign wr_divisor = wr_en && (addr == sdc_pkg::ADDR_DIVISOR);

	// Only bits 4 to 0 are stored; the upper three have no flops at all.
	assign next_control = wr_control ? wr_data[4:0] : control; // RQ1

	assign decimation_value = {decimation_value_high, decimation_value_low}; // RQ12

	assign converting = converter_en &&
		((converter_system_mode == sdc_pkg::SDC_SM_SINGLE) ||
		 (converter_system_mode == sdc_pkg::SDC_SM_CONTINUOUS));

	assign word_end = converting && sample_en && (sample_cnt >= decimation_eff);

	// Half of the modulator clocks in one word, used as the bipolar zero point.
	assign bias = 19'({8'h00, decimation_eff} + 19'h1) * sdc_pkg::HALF_OSR;

	// The sign must come from the difference, not from the raw count.
	assign signed_word = ones_acc - bias;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			control <= sdc_pkg::RESET_CONTROL;
		end else begin
			control <= next_control;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result_polarity_sel <= sdc_pkg::RESET_CONTROL[sdc_pkg::CTRL_POL_BIT];
			burnout_source_en   <= sdc_pkg::RESET_CONTROL[sdc_pkg::CTRL_BURN_BIT];
			gain_select         <= sdc_pkg::RESET_CONTROL[2:0];
			gain_factor         <= 8'h01;
		end else begin
			result_polarity_sel <= next_control[sdc_pkg::CTRL_POL_BIT]; // RQ2
			burnout_source_en   <= next_control[sdc_pkg::CTRL_BURN_BIT]; // RQ3
			gain_select         <= next_control[2:0];
			gain_factor         <= 8'h01 << next_control[2:0]; // RQ4
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			decimation_value_high <= sdc_pkg::RESET_DECIMATION_VALUE_HIGH;
			decimation_value_low  <= sdc_pkg::RESET_DECIMATION_VALUE_LOW;
		end else begin
			if (wr_high) begin
				decimation_value_high <= wr_data[2:0]; // RQ12 RQ13
			end
			if (wr_low) begin
				decimation_value_low <= wr_data;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			divisor <= sdc_pkg::RESET_DIVISOR;
		end else if (wr_divisor) begin
			divisor <= wr_data; // RQ8
		end
	end

	// The filter clamps small settings instead of refusing them.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			decimation_eff <= {sdc_pkg::RESET_DECIMATION_VALUE_HIGH, sdc_pkg::RESET_DECIMATION_VALUE_LOW};
		end else if (decimation_value < sdc_pkg::DECIMATION_VALUE_MIN) begin
			decimation_eff <= sdc_pkg::DECIMATION_VALUE_MIN; // RQ15
		end else begin
			decimation_eff <= decimation_value;
		end
	end

	// A software write to the mode register beats the return to idle at the
	// end of a single conversion, so a new command is never lost.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			converter_en          <= 1'b0;
			converter_system_mode <= sdc_pkg::SDC_SM_IDLE;
		end else if (wr_mode) begin
			converter_en <= wr_data[sdc_pkg::MODE_EN_BIT];
			if (wr_data[sdc_pkg::MODE_EN_BIT]) begin
				converter_system_mode <= wr_data[2:0];
			end else begin
				converter_system_mode <= sdc_pkg::SDC_SM_IDLE; // RQ6
			end
		end else if (word_end &&
			converter_system_mode == sdc_pkg::SDC_SM_SINGLE) begin
			converter_system_mode <= sdc_pkg::SDC_SM_IDLE;
		end else if (!converter_en) begin
			converter_system_mode <= sdc_pkg::SDC_SM_IDLE;
		end
	end

	// The crude decimator counts ones over one word; the polarity bit picks
	// the coding. A real filter would replace this count but keep the timing.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sample_cnt <= 11'h000;
			ones_acc   <= 19'h00000;
		end else if (!converting) begin
			sample_cnt <= 11'h000;
			ones_acc   <= 19'h00000;
		end else begin
			if (word_end) begin
				sample_cnt <= 11'h000; // RQ14
			end else if (sample_en) begin
				sample_cnt <= sample_cnt + 11'h001;
			end
			if (word_end) begin
				ones_acc <= {18'h00000, modulator_clock & mod_bit};
			end else if (modulator_clock) begin
				ones_acc <= ones_acc + {18'h00000, mod_bit}; // RQ11
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result       <= 24'h000000;
			result_valid <= 1'b0;
		end else begin
			result_valid <= word_end; // RQ14
			if (word_end) begin
				if (result_polarity_sel) begin
					result <= {{5{signed_word[18]}}, signed_word}; // RQ2
				end else begin
					result <= {5'h00, ones_acc}; // RQ2 RQ11
				end
			end
		end
	end

	// Read data stand one cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				sdc_pkg::ADDR_CONTROL: begin
					rd_data <= {3'h0, control}; // RQ1
				end
				sdc_pkg::ADDR_DECIMATION_VALUE_HIGH: begin
					rd_data <= {5'h00, decimation_value_high}; // RQ13
				end
				sdc_pkg::ADDR_DECIMATION_VALUE_LOW: begin
					rd_data <= decimation_value_low;
				end
				sdc_pkg::ADDR_DIVISOR: begin
					rd_data <= divisor;
				end
				sdc_pkg::ADDR_MODE: begin
					rd_data <= {converter_en, 4'h0, converter_system_mode};
				end
				default: begin
					rd_data <= 8'h00;
				end
			endcase
		end else begin
			rd_data <= 8'h00;
		end
	end

	// Samples counted between two words, for checking the word rate.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			words_samples <= 11'h000;
		end else if (word_end || !converting) begin
			words_samples <= 11'h000;
		end else if (sample_en) begin
			words_samples <= words_samples + 11'h001;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_ctrl_write_idle;
		wr_en && addr == sdc_pkg::ADDR_CONTROL && idle;
	endsequence

	sequence seq_ctrl_write_busy;
		wr_en && addr == sdc_pkg::ADDR_CONTROL && !idle;
	endsequence

	sequence seq_high_write_busy;
		wr_en && addr == sdc_pkg::ADDR_DECIMATION_VALUE_HIGH && !idle;
	endsequence

	AST_CTRL_UPPER_ZERO: assert property ( // RQ1
		rd_en && addr == sdc_pkg::ADDR_CONTROL |=> rd_data[7:5] == 3'h0)
		else $error("control upper bits not zero on read");

	AST_POLARITY_FOLLOWS: assert property ( // RQ2
		seq_ctrl_write_idle |=> result_polarity_sel == $past(wr_data[4]))
		else $error("polarity select did not take written bit");

	AST_BURNOUT_FOLLOWS: assert property ( // RQ3
		seq_ctrl_write_idle |=> burnout_source_en == $past(wr_data[3]))
		else $error("burnout enable did not take written bit");

	AST_GAIN_FACTOR: assert property ( // RQ4
		gain_factor == (8'h01 << gain_select))
		else $error("gain factor is not two to the gain code");

	AST_CTRL_WRITE_BLOCKED: assert property ( // RQ7
		seq_ctrl_write_busy |=> $stable(control))
		else $error("control changed outside idle");

	AST_HIGH_WRITE_BLOCKED: assert property ( // RQ5
		seq_high_write_busy |=> $stable(decimation_value_high))
		else $error("decimation high changed outside idle");

	AST_HIGH_UPPER_ZERO: assert property ( // RQ13
		rd_en && addr == sdc_pkg::ADDR_DECIMATION_VALUE_HIGH |=>
		rd_data == {5'h00, $past(decimation_value_high)})
		else $error("decimation high read wrong");

	AST_DECIMATION_VALUE_CLAMP: assert property ( // RQ15
		decimation_eff >= sdc_pkg::DECIMATION_VALUE_MIN)
		else $error("effective decimation below minimum");

	AST_WORD_RATE: assert property ( // RQ14
		word_end && $stable(decimation_eff) && words_samples != 11'h000 |->
		words_samples == decimation_eff)
		else $error("word did not span decimation plus one samples");

	AST_SINGLE_ENDS: assert property ( // RQ6
		word_end && converter_system_mode == sdc_pkg::SDC_SM_SINGLE && !wr_en |=>
		idle ##1 result_valid == 1'b0)
		else $error("single conversion did not return to idle");
endmodule : sdc_config

//--- logic/sdc_pkg.sv
// Notes on behaviour
// RQ1: Control bits 7 to 5 read as zero; writes to them do nothing.
// RQ2: Control bit 4 clear gives straight binary results, set gives two's complement.
// RQ3: Control bit 3 set turns the burnout current sources on.
// RQ4: Control bits 2 to 0 select gain of two to the field value.
// RQ5: Control and decimation high registers change only while the converter is idle.
// RQ6: Idle means the 3-bit system mode field holds 000.
// RQ7: A protected write outside idle is dropped and the stored value kept.
// RQ8: Modulator clock is the system clock divided by divisor plus one.
// RQ9: One modulator sample is taken every 128 modulator clocks.
// RQ10: Software should pick a divisor giving about 2.4576 MHz modulator clock.
// RQ11: Single-bit modulator codes are decimated into wide output words.
// RQ12: Decimation value is 11 bits: high register bits 2 to 0, low byte.
// RQ13: Decimation high bits 7 to 3 read as zero; writes ignored.
// RQ14: One output word every 128 times decimation value plus one modulator clocks.
// RQ15: Decimation values below 19 are used as 19.
package sdc_pkg;
	localparam int           CLK_PERIOD_NS    = 4;
	localparam logic [7:0]   ADDR_DECIMATION_VALUE_LOW    = 8'h9A;
	localparam logic [7:0]   ADDR_DECIMATION_VALUE_HIGH   = 8'h9B;
	localparam logic [7:0]   ADDR_MODE        = 8'hF3;
	localparam logic [7:0]   ADDR_CONTROL     = 8'hF4;
	localparam logic [7:0]   ADDR_DIVISOR     = 8'hF7;
	localparam logic [7:0]   RESET_DECIMATION_VALUE_LOW   = 8'hFF;
	localparam logic [2:0]   RESET_DECIMATION_VALUE_HIGH  = 3'h7;
	localparam logic [4:0]   RESET_CONTROL    = 5'h10;
	localparam logic [7:0]   RESET_DIVISOR    = 8'h00;
	localparam int           CTRL_POL_BIT     = 4;
	localparam int           CTRL_BURN_BIT    = 3;
	localparam int           MODE_EN_BIT      = 7;
	localparam logic [6:0]   SAMPLE_LAST      = 7'h7F;
	localparam logic [7:0]   SAMPLE_PERIOD    = 8'h80;
	localparam logic [10:0]  DECIMATION_VALUE_MIN         = 11'h013;
	localparam logic [18:0]  HALF_OSR         = 19'h00040;
	typedef enum logic [2:0] {
		SDC_SM_IDLE       = 3'b000,
		SDC_SM_FULL_CAL   = 3'b001,
		SDC_SM_SINGLE     = 3'b010,
		SDC_SM_CONTINUOUS = 3'b011,
		SDC_SM_INT_OFFSET = 3'b100,
		SDC_SM_INT_GAIN   = 3'b101,
		SDC_SM_SYS_OFFSET = 3'b110,
		SDC_SM_SYS_GAIN   = 3'b111
	} sdc_mode_type;
endpackage : sdc_pkg

//--- logic/sdc_clk_div.sv
`timescale 1ns/10ps
module sdc_clk_div (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] divisor,
	output logic            mod_clk_en,
	output logic            sample_en
);
	logic [7:0] div_cnt;
	logic [6:0] mod_cnt;
	logic [7:0] gap;
	logic       gap_seen;
	logic       div_chg;
	logic [7:0] pulses;

	// Comparing with >= keeps the divider sane if the divisor shrinks mid-count.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt    <= 8'h00;
			mod_clk_en <= 1'b0;
		end else if (div_cnt >= divisor) begin
			div_cnt    <= 8'h00; // RQ8
			mod_clk_en <= 1'b1;
		end else begin
			div_cnt    <= div_cnt + 8'h01;
			mod_clk_en <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mod_cnt   <= 7'h00;
			sample_en <= 1'b0;
		end else begin
			sample_en <= mod_clk_en && (mod_cnt == sdc_pkg::SAMPLE_LAST); // RQ9
			if (mod_clk_en) begin
				mod_cnt <= mod_cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gap      <= 8'h00;
			gap_seen <= 1'b0;
			div_chg  <= 1'b0;
			pulses   <= 8'h00;
		end else begin
			gap      <= mod_clk_en ? 8'h00 : gap + 8'h01;
			gap_seen <= gap_seen | mod_clk_en;
			div_chg  <= mod_clk_en ? 1'b0 : (div_chg | (divisor != $past(divisor)));
			if (sample_en) begin
				pulses <= {7'h00, mod_clk_en};
			end else if (mod_clk_en) begin
				pulses <= pulses + 8'h01;
			end
		end
	end

	AST_MOD_CLK_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
		mod_clk_en && gap_seen && !div_chg && $stable(divisor) |-> gap == divisor)
		else $error("modulator clock period differs from divisor plus one");

	AST_SAMPLE_EVERY_128: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
		sample_en |-> pulses == sdc_pkg::SAMPLE_PERIOD)
		else $error("sample not taken after 128 modulator clocks");
endmodule : sdc_clk_div

//--- testbench/sigma_delta_adc_config_test.sv
`timescale 1ns/10ps
module sigma_delta_adc_config_test;
	typedef struct packed {
		logic [7:0] wdat;
		logic [7:0] rexp;
	} sdc_row_type;

	logic        mclk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic        rd_en;
	logic        mod_bit;
	logic [7:0]  rd_data;
	logic        result_polarity_sel;
	logic        burnout_source_en;
	logic [2:0]  gain_select;
	logic [7:0]  gain_factor;
	logic [2:0]  converter_system_mode;
	logic        converter_en;
	logic        modulator_clock;
	logic        sample_en;
	logic [10:0] decimation_eff;
	logic [23:0] result;
	logic        result_valid;
	int          error_cnt;
	int          n_tests;
	int          n;
	logic [23:0] w;
	sdc_row_type rows [8] = '{'{8'hE0, 8'h00}, '{8'h11, 8'h11}, '{8'hFA, 8'h1A},
		'{8'h0B, 8'h0B}, '{8'h34, 8'h14}, '{8'h0D, 8'h0D}, '{8'hD6, 8'h16}, '{8'hFF, 8'h1F}};

	sdc_config dut_u (
		.mclk                  (mclk),
		.rst_n                 (rst_n),
		.addr                  (addr),
		.wr_data               (wr_data),
		.wr_en                 (wr_en),
		.rd_en                 (rd_en),
		.mod_bit               (mod_bit),
		.rd_data               (rd_data),
		.result_polarity_sel   (result_polarity_sel),
		.burnout_source_en     (burnout_source_en),
		.gain_select           (gain_select),
		.gain_factor           (gain_factor),
		.converter_system_mode (converter_system_mode),
		.converter_en          (converter_en),
		.modulator_clock       (modulator_clock),
		.sample_en             (sample_en),
		.decimation_eff        (decimation_eff),
		.result                (result),
		.result_valid          (result_valid)
	);

	always #2 mclk = ~mclk;

	task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge mclk);
		wr_en   <= 1'b0;
		#1;
	endtask : reg_wr

	task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		chk_val(what, {16'h0000, exp}, {16'h0000, rd_data});
	endtask : chk_rd

	// Waits for a pulse on the chosen output, then counts edges up to the next one.
	task automatic gap(input int sel, output int cnt);
		int k;
		cnt = 0;
		for (k = 0; k < 12000; k++) begin
			@(posedge mclk);
			if ((sel == 0 && modulator_clock === 1'b1) || (sel == 1 && sample_en === 1'b1) ||
			    (sel == 2 && result_valid === 1'b1)) begin
				if (cnt > 0)
					break;
				cnt = 1;
			end else if (cnt > 0) begin
				cnt++;
			end
		end
		if (k == 12000)
			chk_val("pulse timeout", 24'h000001, 24'h000000);
	endtask : gap

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		mclk = 1'b0; rst_n = 1'b0; addr = 8'h00; wr_data = 8'h00;
		wr_en = 1'b0; rd_en = 1'b0; mod_bit = 1'b0; error_cnt = 0; n_tests = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk_val("polarity", 24'h1, {23'h0, result_polarity_sel});
		chk_val("gain factor", 24'h01, {16'h0, gain_factor});
		chk_val("decimation_value eff", 24'h7FF, {13'h0, decimation_eff});
		chk_rd("control", sdc_pkg::ADDR_CONTROL, 8'h10);
		chk_rd("decimation_value high", sdc_pkg::ADDR_DECIMATION_VALUE_HIGH, 8'h07);
		chk_rd("decimation_value low", sdc_pkg::ADDR_DECIMATION_VALUE_LOW, 8'hFF);
		chk_rd("divisor", sdc_pkg::ADDR_DIVISOR, 8'h00);
		chk_rd("mode", sdc_pkg::ADDR_MODE, 8'h00);
		chk_rd("unmapped", 8'h55, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			reg_wr(sdc_pkg::ADDR_CONTROL, rows[i].wdat);
			chk_val("polarity", {23'h0, rows[i].rexp[4]}, {23'h0, result_polarity_sel});
			chk_val("burnout", {23'h0, rows[i].rexp[3]}, {23'h0, burnout_source_en});
			chk_val("gain", {21'h0, rows[i].rexp[2:0]}, {21'h0, gain_select});
			chk_val("gain factor", 24'h1 << rows[i].rexp[2:0], {16'h0, gain_factor});
			chk_rd("control", sdc_pkg::ADDR_CONTROL, rows[i].rexp);
		end
		$display("control table done");
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_HIGH, 8'hFF);
		chk_rd("decimation_value high", sdc_pkg::ADDR_DECIMATION_VALUE_HIGH, 8'h07);
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_HIGH, 8'h00);
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_LOW, 8'h05);
		#8;
		chk_val("decimation_value eff", 24'h013, {13'h0, decimation_eff});
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_LOW, 8'h14);
		#8;
		chk_val("decimation_value eff", 24'h014, {13'h0, decimation_eff});
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_LOW, 8'h12);
		#8;
		chk_val("decimation_value eff", 24'h013, {13'h0, decimation_eff});
		$display("decimation test done");
		reg_wr(sdc_pkg::ADDR_DIVISOR, 8'h03);
		gap(0, n);
		chk_val("modclk gap", 24'd4, n);
		gap(1, n);
		chk_val("sample gap", 24'd512, n);
		reg_wr(sdc_pkg::ADDR_DIVISOR, 8'h00);
		gap(0, n);
		chk_val("modclk gap", 24'd1, n);
		$display("divider test done");
		reg_wr(sdc_pkg::ADDR_CONTROL, 8'h00);
		mod_bit <= 1'b1;
		reg_wr(sdc_pkg::ADDR_MODE, 8'h83);
		chk_val("mode", 24'h3, {21'h0, converter_system_mode});
		chk_rd("mode", sdc_pkg::ADDR_MODE, 8'h83);
		reg_wr(sdc_pkg::ADDR_CONTROL, 8'h1F);
		chk_rd("control", sdc_pkg::ADDR_CONTROL, 8'h00);
		chk_val("burnout", 24'h0, {23'h0, burnout_source_en});
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_HIGH, 8'h05);
		chk_rd("decimation_value high", sdc_pkg::ADDR_DECIMATION_VALUE_HIGH, 8'h00);
		reg_wr(sdc_pkg::ADDR_DECIMATION_VALUE_LOW, 8'h13);
		chk_rd("decimation_value low", sdc_pkg::ADDR_DECIMATION_VALUE_LOW, 8'h12);
		$display("protection test done");
		gap(2, n);
		chk_val("word gap", 24'd2560, n);
		chk_val("unipolar word", 24'h000A00, result);
		reg_wr(sdc_pkg::ADDR_MODE, 8'h03);
		chk_val("mode", 24'h0, {21'h0, converter_system_mode});
		reg_wr(sdc_pkg::ADDR_CONTROL, 8'h10);
		mod_bit <= 1'b0;
		reg_wr(sdc_pkg::ADDR_MODE, 8'h83);
		gap(2, n);
		chk_val("bipolar word", 24'hFFFB00, result);
		reg_wr(sdc_pkg::ADDR_MODE, 8'h80);
		reg_wr(sdc_pkg::ADDR_MODE, 8'h82);
		// A single conversion gives one word only, so wait for one pulse.
		for (n = 0; n < 12000 && result_valid !== 1'b1; n++) @(posedge mclk);
		chk_val("single word", 24'h1, {23'h0, result_valid});
		#8;
		chk_val("mode after single", 24'h0, {21'h0, converter_system_mode});
		$display("conversion test done");
		give_verdict();
	end
endmodule : sigma_delta_adc_config_test
